// File: logic/dcsp_pkg.sv
// Constants and carrier types for the configuration serial port
package dcsp_pkg;
   localparam int          INSTR_BITS  = 16;
   localparam int          BYTE_BITS   = 8;
   localparam logic [3:0]  INSTR_LAST  = 4'hf;
   localparam logic [2:0]  BYTE_LAST   = 3'h7;
   localparam logic [2:0]  NIBBLE_LAST = 3'h3;
   localparam int          DIR_BIT     = 15;

   localparam logic [14:0] IFCFG_ADDR    = 15'h0000;
   localparam logic [14:0] TUNE_ADDR_LO  = 15'h0100;
   localparam int          TUNE_BYTES    = 8;
   localparam logic [14:0] UPD_ADDR      = 15'h0110;
   localparam int          UPD_BIT       = 0;

   typedef struct packed {
      logic soft_reset;
      logic lsb_first;
      logic addr_inc;
      logic sdo_active;
   } dcsp_cfg_t;

   localparam dcsp_cfg_t CFG_RST = '{soft_reset: 1'b0, lsb_first: 1'b0,
                                     addr_inc: 1'b0, sdo_active: 1'b0};

   typedef struct packed {
      logic [14:0] addr;
      logic [7:0]  data;
      logic        we;
      logic        re;
   } dcsp_req_t;

   localparam dcsp_req_t REQ_RST = '{addr: 15'h0000, data: 8'h00, we: 1'b0, re: 1'b0};
endpackage : dcsp_pkg

// File: logic/dcsp_port.sv
// Serial configuration port slave, oversampled by the system clock
`timescale 1ns/100ps
module dcsp_port #(
   parameter logic [14:0] TUNE_LO = dcsp_pkg::TUNE_ADDR_LO,
   parameter int          TUNE_N  = dcsp_pkg::TUNE_BYTES,
   parameter logic [14:0] UPD_A   = dcsp_pkg::UPD_ADDR,
   parameter int          UPD_B   = dcsp_pkg::UPD_BIT
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 sclk,
   input  wire logic                 cs_n,
   input  wire logic                 sdio_i,
   output logic                      sdio_o,
   output logic                      sdio_oe,
   output logic                      dedicated_serial_out,
   output logic                      dedicated_serial_out_oe,
   output dcsp_pkg::dcsp_req_t       reg_req,
   input  wire logic [7:0]           reg_rdata,
   output dcsp_pkg::dcsp_cfg_t       cfg,
   output logic                      soft_reset_pulse,
   output logic [TUNE_N*8-1:0]       tuning_word,
   output logic                      tuning_word_load
);
   import dcsp_pkg::*;

   // Two stages per pin; stage 0 feeds only stage 1
   logic [1:0]          sclk_s_q, cs_s_q, sdio_s_q;
   logic                sclk_prev_q;
   logic                rise, fall;

   logic [15:0]         instr_q, instr_d;
   logic [7:0]          dat_q, dat_d;
   logic [7:0]          rd_q, rd_d;
   logic [3:0]          bcnt_q, bcnt_d;
   logic [2:0]          obit_q, obit_d;
   logic                data_q, data_d;
   logic                rw_q, rw_d;
   logic [14:0]         addr_q, addr_d;
   dcsp_cfg_t           cfg_q, cfg_d;
   dcsp_req_t           req_q, req_d;
   logic                soft_q, soft_d;
   logic                sdio_o_q, sdio_o_d, sdio_oe_q, sdio_oe_d;
   logic                sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;
   logic [7:0]          shadow_q [TUNE_N];
   logic [7:0]          shadow_d [TUNE_N];
   logic [TUNE_N*8-1:0] tune_q, tune_d;
   logic                tload_q, tload_d;

   function automatic logic [14:0] step_addr(input logic [14:0] a, input logic up);
      step_addr = up ? a + 15'h0001 : a - 15'h0001;
   endfunction : step_addr

   function automatic logic in_tune(input logic [14:0] a);
      in_tune = (a >= TUNE_LO) && ({17'h00000, a} < {17'h00000, TUNE_LO} + TUNE_N);
   endfunction : in_tune

   // Read-back image of the interface setting register, halves mirrored
   function automatic logic [7:0] cfg_byte(input dcsp_cfg_t c);
      cfg_byte = {1'b0, c.lsb_first, c.addr_inc, c.sdo_active,
                  c.sdo_active, c.addr_inc, c.lsb_first, 1'b0};
   endfunction : cfg_byte

   assign rise = sclk_s_q[1] & ~sclk_prev_q;
   assign fall = ~sclk_s_q[1] & sclk_prev_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s_q    <= 2'h0;
         cs_s_q      <= 2'h3;
         sdio_s_q    <= 2'h0;
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_s_q    <= {sclk_s_q[0], sclk};
         cs_s_q      <= {cs_s_q[0], cs_n};
         sdio_s_q    <= {sdio_s_q[0], sdio_i};
         sclk_prev_q <= sclk_s_q[1];
      end
   end

   always_comb begin
      logic [15:0] instr_n;
      logic [7:0]  byte_n;
      logic [3:0]  nib;
      logic [14:0] nxt_a;
      logic [14:0] tidx;
      logic        obit;
      instr_n = 16'h0000;
      byte_n  = 8'h00;
      nib     = 4'h0;
      nxt_a   = 15'h0000;
      tidx    = 15'h0000;
      obit    = 1'b0;
      instr_d   = instr_q;
      dat_d     = dat_q;
      rd_d      = rd_q;
      bcnt_d    = bcnt_q;
      obit_d    = obit_q;
      data_d    = data_q;
      rw_d      = rw_q;
      addr_d    = addr_q;
      cfg_d     = cfg_q;
      req_d     = req_q;
      req_d.we  = 1'b0;
      req_d.re  = 1'b0;
      soft_d    = 1'b0;
      sdio_o_d  = sdio_o_q;
      sdio_oe_d = sdio_oe_q;
      sdo_d     = sdo_q;
      sdo_oe_d  = sdo_oe_q;
      shadow_d  = shadow_q;
      tune_d    = tune_q;
      tload_d   = 1'b0;
      // LSB first fills from the top, so both orders land in the same bit places
      instr_n = cfg_q.lsb_first ? {sdio_s_q[1], instr_q[15:1]}
                                : {instr_q[14:0], sdio_s_q[1]};
      byte_n  = cfg_q.lsb_first ? {sdio_s_q[1], dat_q[7:1]}
                                : {dat_q[6:0], sdio_s_q[1]};
      nib     = cfg_q.lsb_first ? {byte_n[4], byte_n[5], byte_n[6], byte_n[7]}
                                : byte_n[3:0];
      nxt_a   = step_addr(addr_q, cfg_q.addr_inc);
      tidx    = addr_q - TUNE_LO;
      if (cs_s_q[1]) begin
         bcnt_d    = 4'h0;
         data_d    = 1'b0;
         obit_d    = 3'h0;
         sdio_oe_d = 1'b0;
         sdo_oe_d  = 1'b0;
      end else begin
         if (rise) begin
            if (!data_q) begin
               instr_d = instr_n;
               bcnt_d  = bcnt_q + 4'h1;
               if (bcnt_q == INSTR_LAST) begin
                  data_d = 1'b1;
                  bcnt_d = 4'h0;
                  obit_d = 3'h0;
                  rw_d   = instr_n[DIR_BIT];
                  addr_d = instr_n[14:0];
                  if (instr_n[DIR_BIT]) begin
                     req_d.re   = 1'b1;
                     req_d.addr = instr_n[14:0];
                  end
               end
            end else if (!rw_q) begin
               dat_d  = byte_n;
               bcnt_d = {1'b0, bcnt_q[2:0] + 3'h1};
               // First nibble received is soft reset, order, step, output enable
               if (addr_q == IFCFG_ADDR && bcnt_q[2:0] == NIBBLE_LAST) begin
                  if (nib[3]) begin
                     cfg_d  = CFG_RST;
                     soft_d = 1'b1;
                  end else begin
                     cfg_d.lsb_first  = nib[2];
                     cfg_d.addr_inc   = nib[1];
                     cfg_d.sdo_active = nib[0];
                  end
               end
               if (bcnt_q[2:0] == BYTE_LAST) begin
                  addr_d = nxt_a;
                  if (addr_q != IFCFG_ADDR) begin
                     if (in_tune(addr_q)) begin
                        shadow_d[tidx[$clog2(TUNE_N)-1:0]] = byte_n;
                     end else begin
                        req_d.we   = 1'b1;
                        req_d.addr = addr_q;
                        req_d.data = byte_n;
                        if (addr_q == UPD_A && byte_n[UPD_B]) begin
                           for (int i = 0; i < TUNE_N; i++) begin
                              tune_d[i*8 +: 8] = shadow_q[i];
                           end
                           tload_d = 1'b1;
                        end
                     end
                  end
               end
            end else begin
               bcnt_d = {1'b0, bcnt_q[2:0] + 3'h1};
               if (bcnt_q[2:0] == BYTE_LAST) begin
                  addr_d     = nxt_a;
                  req_d.re   = 1'b1;
                  req_d.addr = nxt_a;
               end
            end
         end
         if (fall && data_q && rw_q) begin
            obit   = cfg_q.lsb_first ? rd_q[obit_q] : rd_q[BYTE_LAST - obit_q];
            obit_d = obit_q + 3'h1;
            if (cfg_q.sdo_active) begin
               sdo_d    = obit;
               sdo_oe_d = 1'b1;
            end else begin
               sdio_o_d  = obit;
               sdio_oe_d = 1'b1;
            end
         end
      end
      // Fetched data is caught the cycle after the fetch request
      if (req_q.re) begin
         rd_d = (req_q.addr == IFCFG_ADDR) ? cfg_byte(cfg_q) : reg_rdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         instr_q   <= 16'h0000;
         dat_q     <= 8'h00;
         rd_q      <= 8'h00;
         bcnt_q    <= 4'h0;
         obit_q    <= 3'h0;
         data_q    <= 1'b0;
         rw_q      <= 1'b0;
         addr_q    <= 15'h0000;
         cfg_q     <= CFG_RST;
         req_q     <= REQ_RST;
         soft_q    <= 1'b0;
         sdio_o_q  <= 1'b0;
         sdio_oe_q <= 1'b0;
         sdo_q     <= 1'b0;
         sdo_oe_q  <= 1'b0;
         tune_q    <= '0;
         tload_q   <= 1'b0;
         for (int i = 0; i < TUNE_N; i++) begin
            shadow_q[i] <= 8'h00;
         end
      end else begin
         instr_q   <= instr_d;
         dat_q     <= dat_d;
         rd_q      <= rd_d;
         bcnt_q    <= bcnt_d;
         obit_q    <= obit_d;
         data_q    <= data_d;
         rw_q      <= rw_d;
         addr_q    <= addr_d;
         cfg_q     <= cfg_d;
         req_q     <= req_d;
         soft_q    <= soft_d;
         sdio_o_q  <= sdio_o_d;
         sdio_oe_q <= sdio_oe_d;
         sdo_q     <= sdo_d;
         sdo_oe_q  <= sdo_oe_d;
         tune_q    <= tune_d;
         tload_q   <= tload_d;
         shadow_q  <= shadow_d;
      end
   end

   assign sdio_o                  = sdio_o_q;
   assign sdio_oe                 = sdio_oe_q;
   assign dedicated_serial_out    = sdo_q;
   assign dedicated_serial_out_oe = sdo_oe_q;
   assign reg_req                 = req_q;
   assign cfg                     = cfg_q;
   assign soft_reset_pulse        = soft_q;
   assign tuning_word             = tune_q;
   assign tuning_word_load        = tload_q;
endmodule : dcsp_port

// File: verif/dcsp_host.sv
// Serial master model for the configuration port
`timescale 1ns/100ps
module dcsp_host (
   input  wire logic mclk,
   input  wire logic sdio_w,
   input  wire logic dso,
   output logic      sclk    = 1'b0,
   output logic      cs_n    = 1'b1,
   output logic      mosi    = 1'b0,
   output logic      mosi_en = 1'b0
);
   // A positive cut drops select early, after that many bits
   task automatic xfer(input logic [15:0] ins, input int nb, input logic [63:0] wd,
                       input logic lsb, input logic four, input int cut,
                       output logic [63:0] rd);
      int n;
      int b;
      n = cut > 0 ? cut : 16 + 8 * nb;
      rd = '0;
      @(posedge mclk);
      cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         b = (i / 8 - 2) * 8 + (lsb ? i % 8 : 7 - i % 8);
         mosi_en <= i < 16 || !ins[15];
         mosi    <= i < 16 ? ins[lsb ? (i < 15 ? i : 15) : 15 - i] : wd[b];
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         if (i >= 16)
            rd[b] = four ? dso : sdio_w;
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      cs_n    <= 1'b1;
      mosi_en <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask : xfer
endmodule : dcsp_host

// File: verif/dcsp_port_asserts.sv
// Port-level checker for the configuration serial port
`timescale 1ns/100ps
module dcsp_port_asserts #(
   parameter logic [14:0] TUNE_LO = dcsp_pkg::TUNE_ADDR_LO,
   parameter int          TUNE_N  = 8
) (
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic                sclk,
   input wire logic                cs_n,
   input wire logic                sdio_o,
   input wire logic                sdio_oe,
   input wire logic                dedicated_serial_out_oe,
   input wire dcsp_pkg::dcsp_req_t reg_req,
   input wire dcsp_pkg::dcsp_cfg_t cfg,
   input wire logic [TUNE_N*8-1:0] tuning_word,
   input wire logic                tuning_word_load
);
   import dcsp_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_idle_release: assert property (cs_n [*5] |-> !(sdio_oe || dedicated_serial_out_oe))
      else $error("data pin driven while deselected");
   a_launch_fall: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_o) |-> !sclk)
      else $error("read bit changed while clock high");
   a_fetch_drive: assert property (reg_req.re && !(sdio_oe || dedicated_serial_out_oe)
      |-> ##[1:10] (sdio_oe || dedicated_serial_out_oe))
      else $error("read data not driven after fetch");
   a_cfg_nofwd: assert property (reg_req.we |-> reg_req.addr != IFCFG_ADDR)
      else $error("config write forwarded");
   a_tune_nofwd: assert property (reg_req.we |-> reg_req.addr < TUNE_LO
      || reg_req.addr >= TUNE_LO + TUNE_N)
      else $error("tuning write forwarded");
   a_word_load: assert property ($changed(tuning_word) |-> tuning_word_load)
      else $error("tuning word changed without load");
   a_pin_mode: assert property (sdio_oe |-> !cfg.sdo_active)
      else $error("shared pin driven in four-wire mode");
   a_sdo_mode: assert property (dedicated_serial_out_oe |-> cfg.sdo_active)
      else $error("dedicated out driven in three-wire mode");
   a_req_framed: assert property (reg_req.we || reg_req.re |-> !$past(cs_n, 4))
      else $error("register access outside a frame");
   c_write: cover property (reg_req.we);
   c_load: cover property (tuning_word_load);
   c_four: cover property ($rose(dedicated_serial_out_oe));
   c_three: cover property ($rose(sdio_oe));
endmodule : dcsp_port_asserts

bind dcsp_port dcsp_port_asserts #(.TUNE_LO(TUNE_LO), .TUNE_N(TUNE_N)) dcsp_port_asserts_inst (
   .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdio_o(sdio_o),
   .sdio_oe(sdio_oe), .dedicated_serial_out_oe(dedicated_serial_out_oe),
   .reg_req(reg_req), .cfg(cfg), .tuning_word(tuning_word),
   .tuning_word_load(tuning_word_load));

// File: verif/dcsp_port_tb.sv
// Self-checking bench for the configuration serial port
`timescale 1ns/100ps
module dcsp_port_tb;
   import dcsp_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        flip = 1'b0;
   logic        sclk, cs_n, mosi, mosi_en, sdio_o, sdio_oe, dso, dso_oe, twl;
   logic        soft_p, dso_pin;
   logic        sdio_i;
   logic [7:0]  reg_rdata;
   dcsp_req_t   reg_req;
   dcsp_cfg_t   cfg;
   logic [63:0] tw;
   logic [63:0] rd;
   logic [22:0] wq[$];
   int          miscompares = 0;
   int          n_compared = 0;
   int          nload = 0;
   int          nsoft = 0;

   always #50 mclk = ~mclk;
   always @(posedge mclk) flip <= ~flip;
   // Released line toggles so a stale bit never passes for read data
   assign sdio_i = mosi_en ? mosi : sdio_oe ? sdio_o : flip;
   // Undriven dedicated out toggles too, so a missing enable shows up
   assign dso_pin = dso_oe ? dso : flip;
   assign reg_rdata = reg_req.addr[7:0] ^ 8'ha5;
   always @(posedge mclk) begin
      if (reg_req.we)
         wq.push_back({reg_req.addr, reg_req.data});
      if (twl)
         nload++;
      if (soft_p)
         nsoft++;
   end

   dcsp_host dcsp_host_inst (.mclk(mclk), .sdio_w(sdio_i), .dso(dso_pin), .sclk(sclk),
                             .cs_n(cs_n), .mosi(mosi), .mosi_en(mosi_en));
   dcsp_port #(.TUNE_N(8)) dcsp_port_inst (
      .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .dedicated_serial_out(dso),
      .dedicated_serial_out_oe(dso_oe), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .cfg(cfg), .soft_reset_pulse(soft_p), .tuning_word(tw), .tuning_word_load(twl));

   task automatic report_and_stop();
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(string nm, logic [63:0] got, logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(logic [14:0] a, int nb, logic [63:0] d, logic lsb, int step, logic fwd);
      dcsp_host_inst.xfer({1'b0, a}, nb, d, lsb, 1'b0, 0, rd);
      chk("write count", 64'(wq.size()), fwd ? 64'(nb) : 64'h0);
      for (int k = 0; wq.size() > 0; k++)
         chk("write", 64'(wq.pop_front()), {41'h0, 15'(a + step * k), d[k*8 +: 8]});
   endtask : wr

   task automatic rdt(logic [14:0] a, int nb, logic lsb, logic four);
      dcsp_host_inst.xfer({1'b1, a}, nb, 64'h0, lsb, four, 0, rd);
      for (int k = 0; k < nb; k++)
         chk("read", 64'(rd[k*8 +: 8]), 64'(8'(a + k) ^ 8'ha5));
   endtask : rdt

   task automatic t_write_dec();
      wr(15'h0123, 3, 64'h96_5a_c3, 1'b0, -1, 1'b1);
   endtask : t_write_dec

   task automatic t_four_wire();
      wr(IFCFG_ADDR, 1, 64'h2f, 1'b0, 0, 1'b0);
      chk("cfg", 64'(cfg), 64'h2);
      wr(IFCFG_ADDR, 1, 64'h3c, 1'b0, 0, 1'b0);
      chk("cfg", 64'(cfg), 64'h3);
      rdt(15'h0040, 2, 1'b0, 1'b1);
   endtask : t_four_wire

   task automatic t_three_wire_lsb();
      wr(IFCFG_ADDR, 1, 64'h60, 1'b0, 0, 1'b0);
      chk("cfg", 64'(cfg), 64'h6);
      rdt(15'h0205, 2, 1'b1, 1'b0);
      // Setting register reads back with both halves mirrored
      dcsp_host_inst.xfer({1'b1, IFCFG_ADDR}, 1, 64'h0, 1'b1, 1'b0, 0, rd);
      chk("cfg read", 64'(rd[7:0]), 64'h66);
      wr(15'h0301, 2, 64'h5c_a7, 1'b1, 1, 1'b1);
   endtask : t_three_wire_lsb

   task automatic t_abort();
      dcsp_host_inst.xfer(16'h7ff0, 1, 64'h0, 1'b1, 1'b0, 7, rd);
      wr(15'h0402, 1, 64'h3e, 1'b1, 1, 1'b1);
   endtask : t_abort

   task automatic t_tuning();
      wr(TUNE_ADDR_LO, 8, 64'h0123456789abcdef, 1'b1, 1, 1'b0);
      chk("tuning held", tw, 64'h0);
      wr(UPD_ADDR, 1, 64'h01, 1'b1, 1, 1'b1);
      chk("tuning", tw, 64'h0123456789abcdef);
      chk("loads", 64'(nload), 64'h1);
   endtask : t_tuning

   task automatic t_soft();
      wr(IFCFG_ADDR, 1, 64'h01, 1'b1, 0, 1'b0);
      chk("cfg soft", 64'(cfg), 64'h0);
      chk("soft pulses", 64'(nsoft), 64'h1);
   endtask : t_soft

   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_write_dec();
      t_four_wire();
      t_three_wire_lsb();
      t_abort();
      t_tuning();
      t_soft();
      report_and_stop();
   end

   // About 3300 cycles expected; cut off well beyond
   initial begin
      #1_000_000;
      miscompares++;
      report_and_stop();
   end
endmodule : dcsp_port_tb
